// ==== hdl/pcs_synth.sv ====
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module pcs_synth #(
   parameter int N_REFS = 4,
   parameter int N_OUTS = 5,
   parameter int PER_W  = 16
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire logic [N_REFS-1:0]   reference_inputs,
   input  wire logic [1:0]          ref_source_select,
   input  wire logic                pll_reset_low,
   input  wire logic                external_feedback_in,
   input  wire logic [2:0]          phase_shift_value,
   input  wire logic [N_OUTS-1:0]   phase_output_mask,
   input  wire logic                phase_apply_strobe,
   output var  logic [N_OUTS-1:0]   synth_outputs,
   output var  logic                pll_locked
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // word index of an output divider register, or N_OUTS if none
   function automatic int outdiv_index(input logic [7:0] addr);
      int idx;
      idx = N_OUTS;
      for (int k = 0; k < N_OUTS; k++) begin
         if (addr == 8'(pcs_pkg::OFF_OUTDIV0 + 8'(k) * pcs_pkg::WORD_STEP)) begin
            idx = k;
         end
      end
      return idx;
   endfunction

   // shift difference wrapped into one output period of edge events
   function automatic logic [8:0] wrap_shift(input logic signed [4:0] d,
                                             input logic [8:0] per);
      logic signed [10:0] v;
      v = 11'(d);
      for (int k = 0; k < 4; k++) begin
         if (v < 0) begin
            v = v + 11'(per);
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (v >= 11'(per)) begin
            v = v - 11'(per);
         end
      end
      return v[8:0];
   endfunction

   // ------------------------------------------------------------
   // registers and settings
   // ------------------------------------------------------------
   logic              extfb_reg;
   pcs_pkg::pcs_div_t div_reg;
   logic [7:0]        outdiv_reg [N_OUTS];
   logic              cfg_wr_reg;
   logic [23:0]       product;
   logic              cfg_err;
   logic              wr_en;
   logic              rd_setup;
   logic              mapped;
   int                wr_idx;
   logic [31:0]       rd_value;
   logic [PER_W-1:0]  period_reg;

   assign product = 24'(div_reg.m) * 24'(div_reg.o) * 24'(div_reg.cfbk);
   // zero counts or an oversized loop product keep the loop idle
   assign cfg_err = (product > pcs_pkg::MAX_PRODUCT) || (div_reg.n == 8'h00) ||
                    (product == 24'h000000);
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_idx   = outdiv_index(paddr);
   assign mapped   = (paddr == pcs_pkg::OFF_CTRL) || (paddr == pcs_pkg::OFF_DIV) ||
                     (paddr == pcs_pkg::OFF_STATUS) || (wr_idx < N_OUTS);
   assign pready   = 1'b1;  // zero-wait slave
   assign pslverr  = psel && penable && !mapped;

   // control and divider writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extfb_reg  <= 1'b0;
         div_reg    <= pcs_pkg::DIV_RST;
         cfg_wr_reg <= 1'b0;
      end else begin
         cfg_wr_reg <= wr_en && mapped && (paddr != pcs_pkg::OFF_STATUS);
         if (wr_en && paddr == pcs_pkg::OFF_CTRL) begin
            extfb_reg <= pwdata[pcs_pkg::CTRL_EXTFB_BIT];
         end
         if (wr_en && paddr == pcs_pkg::OFF_DIV) begin
            div_reg <= pcs_pkg::pcs_div_t'(pwdata);
         end
      end
   end

   // per-output divider writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < N_OUTS; k++) begin
            outdiv_reg[k] <= pcs_pkg::OUTDIV_RST;
         end
      end else if (wr_en && wr_idx < N_OUTS) begin
         outdiv_reg[wr_idx] <= pwdata[7:0];
      end
   end

   // read mux and read data register, loaded in the setup cycle
   always_comb begin
      rd_value = 32'h00000000;
      if (paddr == pcs_pkg::OFF_CTRL) begin
         rd_value[pcs_pkg::CTRL_EXTFB_BIT] = extfb_reg;
      end else if (paddr == pcs_pkg::OFF_DIV) begin
         rd_value = 32'(div_reg);
      end else if (paddr == pcs_pkg::OFF_STATUS) begin
         rd_value[pcs_pkg::STAT_LOCK_BIT]   = pll_locked;
         rd_value[pcs_pkg::STAT_CFGERR_BIT] = cfg_err;
         rd_value[pcs_pkg::STAT_REFSEL_LSB +: 2] = ref_source_select;
         rd_value[pcs_pkg::STAT_PERIOD_LSB +: 16] = 16'(period_reg);
      end else if (wr_idx < N_OUTS) begin
         rd_value[7:0] = outdiv_reg[wr_idx];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rd_value;
      end
   end

   // ------------------------------------------------------------
   // reference selection and hold
   // ------------------------------------------------------------
   logic        sel_ref;
   logic        ref_prev_reg;
   logic        ext_prev_reg;
   logic [1:0]  sel_reg;
   logic        hold;

   assign sel_ref = reference_inputs[ref_source_select];
   // a select change or a new setting restarts acquisition, covering a
   // fabric that forgets to hold reset around the switch
   assign hold = !pll_reset_low || cfg_err || cfg_wr_reg ||
                 (ref_source_select != sel_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         sel_reg      <= 2'h0;
      end else begin
         ref_prev_reg <= sel_ref;
         ext_prev_reg <= external_feedback_in;
         sel_reg      <= ref_source_select;
      end
   end

   // ------------------------------------------------------------
   // pre-divider and period measurement (edge events = 2x freq)
   // ------------------------------------------------------------
   logic              ref_evt;
   logic              pfd_ref;
   logic [7:0]        pre_cnt_reg;
   logic [PER_W-1:0]  per_cnt_reg;
   logic              per_valid_reg;

   assign ref_evt = sel_ref ^ ref_prev_reg;
   assign pfd_ref = ref_evt && (pre_cnt_reg == div_reg.n - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg   <= 8'h00;
         per_cnt_reg   <= '0;
         period_reg    <= '0;
         per_valid_reg <= 1'b0;
      end else if (hold) begin
         pre_cnt_reg   <= 8'h00;
         per_cnt_reg   <= '0;
         per_valid_reg <= 1'b0;
      end else begin
         if (ref_evt) begin
            pre_cnt_reg <= pfd_ref ? 8'h00 : pre_cnt_reg + 8'h01;
         end
         if (pfd_ref) begin
            per_cnt_reg   <= '0;
            period_reg    <= per_cnt_reg + 1'b1;
            per_valid_reg <= 1'b1;
         end else if (per_cnt_reg != '1) begin
            per_cnt_reg <= per_cnt_reg + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // oscillator: product events per detector period
   // ------------------------------------------------------------
   logic [PER_W:0]    acc_reg;
   logic [PER_W:0]    acc_sum;
   logic              vco_tick;
   logic              aligned_reg;

   assign acc_sum  = acc_reg + (PER_W+1)'(product);
   assign vco_tick = per_valid_reg && aligned_reg &&
                     (acc_sum >= {1'b0, period_reg});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg     <= '0;
         aligned_reg <= 1'b0;
      end else if (hold || !per_valid_reg) begin
         acc_reg     <= '0;
         aligned_reg <= 1'b0;
      end else if (!aligned_reg) begin
         // first detector event after measuring sets the phase origin
         aligned_reg <= pfd_ref;
         acc_reg     <= '0;
      end else if (vco_tick) begin
         acc_reg <= acc_sum - {1'b0, period_reg};
      end else begin
         acc_reg <= acc_sum;
      end
   end

   // ------------------------------------------------------------
   // feedback divider, internal or external path
   // ------------------------------------------------------------
   logic [23:0]  fb_cnt_reg;
   logic [23:0]  fb_div;
   logic         fb_evt;
   logic         fb_pulse;

   assign fb_div   = extfb_reg ? 24'(div_reg.m) : product;
   assign fb_evt   = extfb_reg ? (external_feedback_in ^ ext_prev_reg) : vco_tick;
   assign fb_pulse = aligned_reg && fb_evt && (fb_cnt_reg == fb_div - 24'h000001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_cnt_reg <= 24'h000000;
      end else if (hold || !aligned_reg) begin
         fb_cnt_reg <= 24'h000000;
      end else if (fb_evt) begin
         fb_cnt_reg <= fb_pulse ? 24'h000000 : fb_cnt_reg + 24'h000001;
      end
   end

   // ------------------------------------------------------------
   // lock detector: both pulses inside a small window
   // ------------------------------------------------------------
   logic [2:0]  ref_win_reg;
   logic [2:0]  fb_win_reg;
   logic [3:0]  match_reg;
   logic        good;
   logic        bad;

   assign good = (pfd_ref && fb_pulse) || (pfd_ref && fb_win_reg != 3'h0) ||
                 (fb_pulse && ref_win_reg != 3'h0);
   assign bad  = !good && aligned_reg &&
                 ((ref_win_reg == 3'h1) || (fb_win_reg == 3'h1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_win_reg <= 3'h0;
         fb_win_reg  <= 3'h0;
      end else if (hold || good || !aligned_reg) begin
         ref_win_reg <= 3'h0;
         fb_win_reg  <= 3'h0;
      end else begin
         if (pfd_ref) begin
            ref_win_reg <= pcs_pkg::LOCK_TOL;
         end else if (ref_win_reg != 3'h0) begin
            ref_win_reg <= ref_win_reg - 3'h1;
         end
         if (fb_pulse) begin
            fb_win_reg <= pcs_pkg::LOCK_TOL;
         end else if (fb_win_reg != 3'h0) begin
            fb_win_reg <= fb_win_reg - 3'h1;
         end
      end
   end

   // lock flag: set after enough matches, dropped on any miss
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_reg  <= 4'h0;
         pll_locked <= 1'b0;
      end else if (hold || bad) begin
         match_reg  <= 4'h0;
         pll_locked <= 1'b0;
      end else begin
         if (good && match_reg != pcs_pkg::LOCK_MATCHES) begin
            match_reg <= match_reg + 4'h1;
         end
         pll_locked <= (match_reg == pcs_pkg::LOCK_MATCHES);
      end
   end

   // ------------------------------------------------------------
   // post-divider and output dividers with phase shift
   // ------------------------------------------------------------
   logic [7:0]  post_cnt_reg;
   logic        pll_tick;

   assign pll_tick = vco_tick && (post_cnt_reg == div_reg.o - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_cnt_reg <= 8'h00;
      end else if (hold || !aligned_reg) begin
         post_cnt_reg <= 8'h00;
      end else if (vco_tick) begin
         post_cnt_reg <= pll_tick ? 8'h00 : post_cnt_reg + 8'h01;
      end
   end

   generate
      for (genvar g = 0; g < N_OUTS; g++) begin : g_out
         logic [7:0]  cnt_reg;
         logic [2:0]  shift_reg;
         logic [8:0]  delay_reg;
         logic [8:0]  out_per;

         assign out_per = {outdiv_reg[g], 1'b0};

         // applied shift per output, latched on the strobe
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               shift_reg <= 3'h0;
            end else if (phase_apply_strobe && phase_output_mask[g]) begin
               shift_reg <= phase_shift_value;
            end
         end

         // each pending half-cycle stalls the output counter one event
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_reg          <= 8'h00;
               delay_reg        <= 9'h000;
               synth_outputs[g] <= 1'b0;
            end else if (hold || !aligned_reg) begin
               cnt_reg          <= 8'h00;
               delay_reg        <= 9'(shift_reg);
               synth_outputs[g] <= 1'b0;
            end else begin
               // a strobe landing on a tick must not swallow that tick
               if (phase_apply_strobe && phase_output_mask[g]) begin
                  delay_reg <= delay_reg + wrap_shift(
                     5'(phase_shift_value) - 5'(shift_reg), out_per) -
                     9'(pll_tick && delay_reg != 9'h000);
               end else if (pll_tick && delay_reg != 9'h000) begin
                  delay_reg <= delay_reg - 9'h001;
               end
               if (pll_tick && delay_reg == 9'h000) begin
                  if (cnt_reg == outdiv_reg[g] - 8'h01) begin
                     cnt_reg          <= 8'h00;
                     synth_outputs[g] <= !synth_outputs[g];
                  end else begin
                     cnt_reg <= cnt_reg + 8'h01;
                  end
               end
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ==== include/pcs_pkg.sv ====
package pcs_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFF_CTRL        = 8'h00;
   localparam logic [7:0]  OFF_DIV         = 8'h04;
   localparam logic [7:0]  OFF_OUTDIV0     = 8'h08; // five words, 0x08..0x18
   localparam logic [7:0]  OFF_STATUS      = 8'h1c;
   localparam logic [7:0]  WORD_STEP       = 8'h04;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          CTRL_EXTFB_BIT  = 0;
   localparam int          STAT_LOCK_BIT   = 0;
   localparam int          STAT_CFGERR_BIT = 1;
   localparam int          STAT_REFSEL_LSB = 4;
   localparam int          STAT_PERIOD_LSB = 16;

   // ------------------------------------------------------------
   // counter settings, packed as the divider register holds them
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfbk;   // feedback divider
      logic [7:0] o;      // post-divider
      logic [7:0] m;      // feedback multiplier
      logic [7:0] n;      // reference pre-divider
   } pcs_div_t;

   localparam pcs_div_t    DIV_RST     = 32'h01010101;
   localparam logic [7:0]  OUTDIV_RST  = 8'h01;
   localparam logic [23:0] MAX_PRODUCT = 24'h0000ff;

   // ------------------------------------------------------------
   // lock detector and timing
   // ------------------------------------------------------------
   localparam logic [2:0]  LOCK_TOL     = 3'h2; // pclk cycles of slack
   localparam logic [3:0]  LOCK_MATCHES = 4'h4; // aligned compares to lock
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          RESET_MIN_NS  = 10;
   localparam int          RESET_MIN_CYC =
      ((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== verif/pcs_synth_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module pcs_synth_properties #(
   parameter int N_OUTS = 5
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic [1:0]        ref_source_select,
   input wire logic              pll_reset_low,
   input wire logic [N_OUTS-1:0] synth_outputs,
   input wire logic              pll_locked
);
   // ------------------------------------------------------------
   // helper decode
   // ------------------------------------------------------------
   logic        wr_cfg;
   logic        err_wr;
   logic [23:0] prod;

   // config writes, and divider words outside the legal range
   assign wr_cfg = psel && penable && pwrite && paddr < pcs_pkg::OFF_STATUS;
   assign prod   = pwdata[15:8] * pwdata[23:16] * pwdata[31:24];
   assign err_wr = wr_cfg && paddr == pcs_pkg::OFF_DIV &&
                   (pwdata[7:0] == 8'h00 || prod == 24'h000000 ||
                    prod > pcs_pkg::MAX_PRODUCT);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_hold_clears: assert property (!pll_reset_low |=>
      !pll_locked && synth_outputs == '0) else $error("hold not clearing");
   a_lock_late: assert property ($rose(pll_reset_low) |->
      !pll_locked [*5]) else $error("lock too soon after release");
   a_sel_restart: assert property ($changed(ref_source_select) |->
      ##3 !pll_locked [*3]) else $error("select change kept lock");
   a_cfg_restart: assert property (wr_cfg |-> ##3 !pll_locked [*3])
      else $error("config write kept lock");
   a_err_nolock: assert property (err_wr |-> ##2 !pll_locked [*8])
      else $error("lock with illegal dividers");
   a_err_idle: assert property (err_wr |-> ##3 (synth_outputs == '0) [*5])
      else $error("outputs run with illegal dividers");
   a_stat_lock: assert property (psel && penable && !pwrite &&
      paddr == pcs_pkg::OFF_STATUS |-> prdata[0] == $past(pll_locked))
      else $error("status lock bit differs");
   a_bad_addr: assert property (psel && penable &&
      paddr > pcs_pkg::OFF_STATUS |-> pslverr && (pwrite || prdata == '0))
      else $error("unmapped access not refused");
   a_err_only_bad: assert property (pslverr |-> psel && penable &&
      (paddr > pcs_pkg::OFF_STATUS || paddr[1:0] != 2'h0))
      else $error("error on mapped access");
endmodule

bind pcs_synth pcs_synth_properties #(.N_OUTS(N_OUTS)) i_props (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
   .ref_source_select, .pll_reset_low, .synth_outputs, .pll_locked);

`default_nettype wire

// ==== verif/pcs_fabric_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module pcs_fabric_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] want_select,
   input  wire logic       synth_out0,
   output logic [3:0]      reference_inputs,
   output logic [1:0]      ref_source_select,
   output logic            pll_reset_low,
   output logic            external_feedback_in
);
   logic [3:0] ref_cnt [4];
   logic [3:0] hold_cnt;

   // reference i toggles every 4+i pclk cycles, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_inputs <= 4'h0;
         for (int i = 0; i < 4; i++) ref_cnt[i] <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (ref_cnt[i] == 4'(3 + i)) begin
               ref_cnt[i]          <= 4'h0;
               reference_inputs[i] <= ~reference_inputs[i];
            end else begin
               ref_cnt[i] <= ref_cnt[i] + 4'h1;
            end
         end
      end
   end

   // reset sequencer: reset wraps every select change by four cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_reset_low     <= 1'b0;
         ref_source_select <= 2'h0;
         hold_cnt          <= 4'h8;
      end else if (pll_reset_low && want_select != ref_source_select) begin
         pll_reset_low <= 1'b0;
         hold_cnt      <= 4'h8;
      end else if (hold_cnt != 4'h0) begin
         hold_cnt <= hold_cnt - 4'h1;
         if (hold_cnt == 4'h4) ref_source_select <= want_select;
      end else begin
         pll_reset_low <= 1'b1;
      end
   end

   // single stage closes its loop from output zero, nothing chained
   assign external_feedback_in = synth_out0;
endmodule

`default_nettype wire

// ==== verif/pcs_synth_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module pcs_synth_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  reference_inputs;
   logic [1:0]  ref_source_select;
   logic [1:0]  want_sel;
   logic        pll_reset_low;
   logic        external_feedback_in;
   logic [2:0]  phase_shift_value;
   logic [4:0]  phase_output_mask;
   logic        phase_apply_strobe;
   logic [4:0]  synth_outputs;
   logic        pll_locked;
   logic [31:0] q;
   logic        e;
   int          fail_count;
   int          cmp_count;
   int          d;
   int          tog [5];
   logic [31:0] cfg_tab [4] = '{32'h01010100, 32'h0101ff01,
                                32'h01101001, 32'h00010101};
   logic        err_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

   // ------------------------------------------------------------
   // clock, design and fabric model
   // ------------------------------------------------------------
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   pcs_synth i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .reference_inputs,
      .ref_source_select, .pll_reset_low, .external_feedback_in,
      .phase_shift_value, .phase_output_mask, .phase_apply_strobe,
      .synth_outputs, .pll_locked);

   pcs_fabric_model i_fabric (.pclk, .presetn, .want_select(want_sel),
      .synth_out0(synth_outputs[0]), .reference_inputs, .ref_source_select,
      .pll_reset_low, .external_feedback_in);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; read data and error land in q and e
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk("pready", 32'h0, 32'h1);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, q & m, x);
   endtask

   // let a restart land, then wait a bounded time for lock
   task automatic wait_lock();
      int n;
      repeat (4) @(posedge pclk);
      n = 0;
      while (pll_locked !== 1'b1 && n < 600) begin
         @(posedge pclk);
         n++;
      end
      chk("lock", {31'h0, pll_locked}, 32'h1);
   endtask

   task automatic measure(input int cyc);
      logic [4:0] prev;
      prev = synth_outputs;
      for (int k = 0; k < 5; k++) tog[k] = 0;
      repeat (cyc) begin
         @(posedge pclk);
         for (int k = 0; k < 5; k++) if (synth_outputs[k] !== prev[k]) tog[k]++;
         prev = synth_outputs;
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {want_sel, phase_shift_value, phase_output_mask} = '0;
      phase_apply_strobe = 1'b0;
      fail_count = 0;
      cmp_count  = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl", pcs_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
      rdc("div", pcs_pkg::OFF_DIV, 32'hffffffff, pcs_pkg::DIV_RST);
      for (int k = 0; k < 5; k++)
         rdc("outdiv", pcs_pkg::OFF_OUTDIV0 + 8'(4 * k), 32'hff, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", q, 32'h0);
      apb(1'b1, pcs_pkg::OFF_STATUS, 32'hffffffff);
      rdc("status ro", pcs_pkg::OFF_STATUS, 32'h2, 32'h0);
      $display("test reset and map done");
      wait_lock();
      rdc("status", pcs_pkg::OFF_STATUS, 32'h33, 32'h01);
      $display("test lock done");
      // output k divides by k+1, multiplier 2; ref 0 edges every 4 cycles
      for (int k = 0; k < 5; k++)
         apb(1'b1, pcs_pkg::OFF_OUTDIV0 + 8'(4 * k), 32'(k + 1));
      apb(1'b1, pcs_pkg::OFF_DIV, 32'h01010201);
      wait_lock();
      measure(96);
      for (int k = 0; k < 5; k++) begin
         d = tog[k] - (96 / 4) * 2 / (k + 1);
         chk("toggles", {31'h0, d >= -2 && d <= 2}, 32'h1);
      end
      $display("test frequency done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, pcs_pkg::OFF_DIV, cfg_tab[i]);
         repeat (40) @(posedge pclk);
         rdc("cfgerr", pcs_pkg::OFF_STATUS, 32'h2, {30'h0, err_tab[i], 1'b0});
         if (err_tab[i]) chk("err lock", {31'h0, pll_locked}, 32'h0);
      end
      apb(1'b1, pcs_pkg::OFF_DIV, 32'h01010201);
      $display("test divider limits done");
      for (int i = 1; i <= 4; i++) begin
         want_sel <= 2'(i % 4);
         repeat (12) @(posedge pclk);
         wait_lock();
         rdc("select", pcs_pkg::OFF_STATUS, 32'h30, 32'((i % 4) << 4));
      end
      $display("test reference switch done");
      apb(1'b1, pcs_pkg::OFF_CTRL, 32'h1);
      wait_lock();
      rdc("ctrl", pcs_pkg::OFF_CTRL, 32'h1, 32'h1);
      apb(1'b1, pcs_pkg::OFF_CTRL, 32'h0);
      $display("test external feedback done");
      apb(1'b1, pcs_pkg::OFF_OUTDIV0, 32'h4);
      apb(1'b1, pcs_pkg::OFF_OUTDIV0 + 8'h04, 32'h4);
      wait_lock();
      repeat (8) @(posedge pclk);
      chk("aligned", {31'h0, synth_outputs[0] ^ synth_outputs[1]}, 32'h0);
      @(posedge pclk);
      phase_shift_value  <= 3'h4;
      phase_output_mask  <= 5'h01;
      phase_apply_strobe <= 1'b1;
      @(posedge pclk);
      phase_apply_strobe <= 1'b0;
      repeat (40) @(posedge pclk);
      // four half steps on a divide-by-four output: half a period late
      for (int i = 0; i < 8; i++) begin
         repeat (3) @(posedge pclk);
         chk("shifted", {31'h0, synth_outputs[0] ^ synth_outputs[1]}, 32'h1);
      end
      $display("test phase shift done");
      finish_test();
   end

   // watchdog well beyond the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("watchdog expired");
      finish_test();
   end
endmodule

`default_nettype wire
